// ### src/dpmdio_pkg.sv
// Shared constants for the dual-port serial management link
package dpmdio_pkg;
  localparam int unsigned DPMDIO_PREAMBLE_BITS = 32;
  localparam logic [1:0] DPMDIO_START = 2'h1;
  localparam logic [1:0] DPMDIO_OP_READ = 2'h2;
  localparam logic [1:0] DPMDIO_OP_WRITE = 2'h1;
  localparam logic [1:0] DPMDIO_TA_WRITE = 2'h2;
  localparam int unsigned DPMDIO_HDR_BITS = 14;
  localparam int unsigned DPMDIO_DATA_BITS = 16;
  localparam int unsigned DPMDIO_NREGS = 32;
  localparam logic [4:0] DPMDIO_REG_STATUS = 5'h01;
  localparam logic [4:0] DPMDIO_REG_BYPASS = 5'h17;
  localparam int unsigned DPMDIO_STATUS_SUPPR_BIT = 6;
  localparam int unsigned DPMDIO_BYPASS_SIMWR_BIT = 15;
  localparam logic [15:0] DPMDIO_STATUS_RESET = 16'h0040;
  localparam logic [15:0] DPMDIO_REG_RESET = 16'h0000;
  // Host register map on AHB-Lite
  localparam logic [7:0] DPMDIO_CMD_OFS = 8'h00;
  localparam logic [7:0] DPMDIO_WDATA_OFS = 8'h04;
  localparam logic [7:0] DPMDIO_STAT_OFS = 8'h08;
  localparam logic [7:0] DPMDIO_CFG_OFS = 8'h0c;
  localparam int unsigned DPMDIO_CMD_GO_BIT = 31;
  localparam int unsigned DPMDIO_CMD_WR_BIT = 30;
  localparam int unsigned DPMDIO_CFG_SUPPR_BIT = 0;
  localparam logic [7:0] DPMDIO_CLK_DIV_DEFAULT = 8'h02;
  localparam int unsigned DPMDIO_MAX_MDC_MHZ = 25;
endpackage

// ### src/dpmdio_if.sv
// Two-wire management link between station and dual-port device
`timescale 1ns/1ps
interface dpmdio_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;
  // Pull-up holds the line high when nobody drives
  assign mdio = sta_mdio_oe ? sta_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);
  modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
  modport device (input mdc, output dev_mdio_o, output dev_mdio_oe, input mdio);
endinterface

// ### src/dpmdio_device.sv
// Management slave of the dual-port device, clocked by the link clock
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module dpmdio_device
  import dpmdio_pkg::*;
(
  dpmdio_if.device link,
  input wire logic link_rst,
  input wire logic [4:0] port_a_addr,
  input wire logic [4:0] port_b_addr,
  output logic [15:0] port_a_bypass,
  output logic [15:0] port_b_bypass
);

  typedef enum logic [5:0] {
    DPMDIO_S_UNSYNC = 6'h01,
    DPMDIO_S_IDLE = 6'h02,
    DPMDIO_S_HDR = 6'h04,
    DPMDIO_S_TA = 6'h08,
    DPMDIO_S_RDATA = 6'h10,
    DPMDIO_S_WDATA = 6'h20
  } dpmdio_dev_state_t;

  // Port 0 is A, port 1 is B
  logic [15:0] regs_q [2][DPMDIO_NREGS];
  logic [15:0] regs_d [2][DPMDIO_NREGS];
  dpmdio_dev_state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [13:0] hdr_q, hdr_d;
  logic [15:0] sh_q, sh_d;
  logic sel_q, sel_d;
  logic port_q, port_d;
  logic oe_q, oe_d;
  logic o_q, o_d;
  logic [13:0] hdr_n;
  logic [15:0] rd_word;

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  assign hdr_n = {hdr_q[12:0], link.mdio};
  assign rd_word = regs_q[port_q][hdr_q[4:0]];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    sh_d = sh_q;
    sel_d = sel_q;
    port_d = port_q;
    oe_d = 1'b0;
    o_d = 1'b1;
    regs_d = regs_q;
    unique case (state_q)
      DPMDIO_S_UNSYNC: begin
        if (!link.mdio) begin
          cnt_d = '0;
        end else if (cnt_q < 6'(DPMDIO_PREAMBLE_BITS - 1)) begin
          cnt_d = cnt_q + 6'h01;
        end else begin
          state_d = DPMDIO_S_IDLE;
        end
      end
      DPMDIO_S_IDLE: begin
        // a zero after idle opens a frame
        if (!link.mdio) begin
          state_d = DPMDIO_S_HDR;
          cnt_d = '0;
          hdr_d = '0;
        end
      end
      DPMDIO_S_HDR: begin
        hdr_d = hdr_n;
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'(DPMDIO_HDR_BITS - 2)) begin
          // hdr_n = start(1 bit), op, phy, reg
          if (!hdr_n[12] || hdr_n[11:10] == 2'h0 || hdr_n[11:10] == 2'h3) begin
            state_d = DPMDIO_S_UNSYNC;
            cnt_d = '0;
          end else begin
            state_d = DPMDIO_S_TA;
            cnt_d = '0;
            sel_d = (hdr_n[9:5] == port_a_addr) || (hdr_n[9:5] == port_b_addr);
            port_d = (hdr_n[9:5] != port_a_addr);
            // Line stays released through the first turnaround bit
            oe_d = 1'b0;
          end
        end
      end
      DPMDIO_S_TA: begin
        // First turnaround bit sampled here; on a read to a selected port a zero goes out for the second
        if (hdr_q[11:10] == DPMDIO_OP_READ) begin
          state_d = DPMDIO_S_RDATA;
          sh_d = rd_word;
          cnt_d = '0;
          if (sel_q) begin
            oe_d = 1'b1;
            o_d = 1'b0;
          end
        end else if (cnt_q == 6'h00) begin
          cnt_d = 6'h01;
          if (!link.mdio) begin
            state_d = DPMDIO_S_UNSYNC;
            cnt_d = '0;
          end
        end else if (link.mdio) begin
          state_d = DPMDIO_S_UNSYNC;
          cnt_d = '0;
        end else begin
          state_d = DPMDIO_S_WDATA;
          cnt_d = '0;
        end
      end
      DPMDIO_S_RDATA: begin
        // Data MSB goes out first, then 15 more shifts
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'h00) begin
          oe_d = sel_q;
          o_d = sh_q[15];
        end else if (cnt_q < 6'(DPMDIO_DATA_BITS)) begin
          sh_d = {sh_q[14:0], 1'b1};
          oe_d = sel_q;
          o_d = sh_q[14];
          if (cnt_q == 6'(DPMDIO_DATA_BITS - 1)) begin
            oe_d = sel_q;
          end
        end else begin
          state_d = DPMDIO_S_IDLE;
        end
      end
      DPMDIO_S_WDATA: begin
        sh_d = {sh_q[14:0], link.mdio};
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'(DPMDIO_DATA_BITS - 1)) begin
          state_d = DPMDIO_S_IDLE;
          if (sel_q && hdr_q[4:0] != DPMDIO_REG_STATUS) begin
            regs_d[port_q][hdr_q[4:0]] = {sh_q[14:0], link.mdio};
            // simultaneous write mirrors port A writes
            if (!port_q && regs_q[0][DPMDIO_REG_BYPASS][DPMDIO_BYPASS_SIMWR_BIT]) begin
              regs_d[1][hdr_q[4:0]] = {sh_q[14:0], link.mdio};
            end
          end
        end
      end
      default: begin
        state_d = DPMDIO_S_UNSYNC;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge link.mdc) begin
    if (link_rst) begin
      state_q <= DPMDIO_S_UNSYNC;
      cnt_q <= '0;
      hdr_q <= '0;
      sh_q <= '0;
      sel_q <= 1'b0;
      port_q <= 1'b0;
      oe_q <= 1'b0;
      o_q <= 1'b1;
      for (int p = 0; p < 2; p++) begin
        for (int r = 0; r < DPMDIO_NREGS; r++) begin
          regs_q[p][r] <= (5'(r) == DPMDIO_REG_STATUS) ? DPMDIO_STATUS_RESET
                                                       : DPMDIO_REG_RESET;
        end
      end
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      sh_q <= sh_d;
      sel_q <= sel_d;
      port_q <= port_d;
      oe_q <= oe_d;
      o_q <= o_d;
      regs_q <= regs_d;
    end
  end

  // ----------------------------------------
  // Line drive
  // ----------------------------------------
  assign link.dev_mdio_oe = oe_q;
  assign link.dev_mdio_o = o_q;
  assign port_a_bypass = regs_q[0][DPMDIO_REG_BYPASS];
  assign port_b_bypass = regs_q[1][DPMDIO_REG_BYPASS];

endmodule

// ### src/dpmdio_station.sv
// Station management end: AHB-Lite registers on clk, link clock made by divider
`timescale 1ns/1ps
module dpmdio_station
  import dpmdio_pkg::*;
(
  dpmdio_if.station link,
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  typedef enum logic [2:0] {
    DPMDIO_H_IDLE = 3'h1,
    DPMDIO_H_PRE = 3'h2,
    DPMDIO_H_FRAME = 3'h4
  } dpmdio_sta_state_t;

  dpmdio_sta_state_t st_q, st_d;
  logic wph_q, wph_d;
  logic [7:0] wad_q, wad_d;
  logic [31:0] cmd_q, cmd_d;
  logic [15:0] rdat_q, rdat_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic suppr_q, suppr_d;
  logic init_q, init_d;
  logic [7:0] div_q, div_d;
  logic mdc_q, mdc_d;
  logic [6:0] bit_q, bit_d;
  logic [63:0] sh_q, sh_d;
  logic oe_q, oe_d;
  logic o_q, o_d;
  logic [31:0] rd_mux;
  logic rise, fall;
  logic [2:0] mdio_sync_q, mdio_sync_d;
  logic mdio_filt_q, mdio_filt_d;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    unique case (haddr)
      DPMDIO_CMD_OFS: rd_mux = cmd_q;
      DPMDIO_STAT_OFS: rd_mux = {14'h0, done_q, busy_q, rdat_q};
      DPMDIO_CFG_OFS: rd_mux = {31'h0, suppr_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Link sequencer, MDC from divider
  // ----------------------------------------
  assign rise = (div_q == DPMDIO_CLK_DIV_DEFAULT) && !mdc_q;
  assign fall = (div_q == DPMDIO_CLK_DIV_DEFAULT) && mdc_q;

  always_comb begin
    wph_d = hsel && hready && htrans[1] && hwrite;
    wad_d = haddr;
    cmd_d = cmd_q;
    suppr_d = suppr_q;
    st_d = st_q;
    busy_d = busy_q;
    done_d = done_q;
    rdat_d = rdat_q;
    init_d = init_q;
    div_d = (div_q == DPMDIO_CLK_DIV_DEFAULT) ? 8'h00 : div_q + 8'h01;
    mdc_d = (div_q == DPMDIO_CLK_DIV_DEFAULT) ? ~mdc_q : mdc_q;
    bit_d = bit_q;
    sh_d = sh_q;
    oe_d = oe_q;
    o_d = o_q;
    // Line comes from the link clock: three stages, change taken once two agree
    mdio_sync_d = {mdio_sync_q[1:0], link.mdio};
    mdio_filt_d = (mdio_sync_q[1] == mdio_sync_q[2]) ? mdio_sync_q[2] : mdio_filt_q;
    if (wph_q && wad_q == DPMDIO_CFG_OFS) begin
      suppr_d = hwdata[DPMDIO_CFG_SUPPR_BIT];
    end
    unique case (st_q)
      DPMDIO_H_IDLE: begin
        oe_d = 1'b0;
        if (wph_q && wad_q == DPMDIO_CMD_OFS && hwdata[DPMDIO_CMD_GO_BIT]) begin
          cmd_d = hwdata;
          busy_d = 1'b1;
          done_d = 1'b0;
          bit_d = '0;
          // preamble unless suppressed after first sync
          st_d = (suppr_q && init_q) ? DPMDIO_H_FRAME : DPMDIO_H_PRE;
          sh_d = {DPMDIO_START,
                  hwdata[DPMDIO_CMD_WR_BIT] ? DPMDIO_OP_WRITE : DPMDIO_OP_READ,
                  hwdata[25:16], DPMDIO_TA_WRITE, hwdata[15:0], 32'hffffffff};
        end
      end
      DPMDIO_H_PRE: begin
        if (fall) begin
          oe_d = 1'b1;
          o_d = 1'b1;
          bit_d = bit_q + 7'h01;
          if (bit_q == 7'(DPMDIO_PREAMBLE_BITS)) begin
            st_d = DPMDIO_H_FRAME;
            bit_d = '0;
          end
        end
      end
      DPMDIO_H_FRAME: begin
        if (fall) begin
          bit_d = bit_q + 7'h01;
          o_d = sh_q[63];
          sh_d = {sh_q[62:0], 1'b1};
          oe_d = cmd_q[DPMDIO_CMD_WR_BIT] || bit_q < 7'(DPMDIO_HDR_BITS);
          if (bit_q == 7'(DPMDIO_HDR_BITS + 2 + DPMDIO_DATA_BITS)) begin
            oe_d = 1'b0; // idle bit follows
            st_d = DPMDIO_H_IDLE;
            busy_d = 1'b0;
            done_d = 1'b1;
            init_d = 1'b1;
          end
        end
        if (rise && !cmd_q[DPMDIO_CMD_WR_BIT] && bit_q > 7'(DPMDIO_HDR_BITS + 2) &&
            bit_q <= 7'(DPMDIO_HDR_BITS + 2 + DPMDIO_DATA_BITS)) begin
          rdat_d = {rdat_q[14:0], mdio_filt_q};
        end
      end
      default: st_d = DPMDIO_H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wph_q <= 1'b0;
      wad_q <= '0;
      cmd_q <= '0;
      suppr_q <= 1'b0;
      st_q <= DPMDIO_H_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdat_q <= '0;
      init_q <= 1'b0;
      div_q <= '0;
      mdc_q <= 1'b0;
      bit_q <= '0;
      sh_q <= '1;
      oe_q <= 1'b0;
      o_q <= 1'b1;
      mdio_sync_q <= '1;
      mdio_filt_q <= 1'b1;
      hrdata <= '0;
    end else begin
      wph_q <= wph_d;
      wad_q <= wad_d;
      cmd_q <= cmd_d;
      suppr_q <= suppr_d;
      st_q <= st_d;
      busy_q <= busy_d;
      done_q <= done_d;
      rdat_q <= rdat_d;
      init_q <= init_d;
      div_q <= div_d;
      mdc_q <= mdc_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      oe_q <= oe_d;
      o_q <= o_d;
      mdio_sync_q <= mdio_sync_d;
      mdio_filt_q <= mdio_filt_d;
      hrdata <= (hsel && hready && htrans[1] && !hwrite) ? rd_mux : hrdata;
    end
  end

  assign link.mdc = mdc_q; // clk/6 stays under 25 MHz
  assign link.sta_mdio_oe = oe_q;
  assign link.sta_mdio_o = o_q;

endmodule

// ### tb/dpmdio_sva.sv
// Protocol assertions on the management link wires
`timescale 1ns/1ps
module dpmdio_sva (
  input wire logic mdc,
  input wire logic link_rst,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio
);
  // ----------------------------------------
  // Length of device drive
  // ----------------------------------------
  logic [5:0] run_q;
  logic [5:0] run_d;
  always_comb begin
    run_d = dev_mdio_oe ? run_q + 6'h01 : 6'h00;
  end
  always_ff @(posedge mdc) begin
    run_q <= link_rst ? 6'h00 : run_d;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mdc);
  endclocking
  default disable iff (link_rst);
  sequence s_handover;
    sta_mdio_oe ##1 (!sta_mdio_oe && !dev_mdio_oe) ##1 dev_mdio_oe;
  endsequence
  AST_NO_CONTENTION: assert property (!(sta_mdio_oe && dev_mdio_oe))
    else $error("both ends drive the line");
  AST_TA_ZERO: assert property (s_handover |-> !dev_mdio_o)
    else $error("second turnaround bit not zero");
  AST_TA_FLOAT: assert property ($rose(dev_mdio_oe) |->
    $past(sta_mdio_oe, 2) && !$past(sta_mdio_oe) && !$past(dev_mdio_oe))
    else $error("first turnaround bit driven");
  AST_READ_LEN: assert property ($fell(dev_mdio_oe) |-> run_q == 6'h11)
    else $error("read drive not 17 bits");
  AST_START_CODE: assert property ($rose(dev_mdio_oe) |->
    !$past(mdio, 15) && $past(mdio, 14))
    else $error("reply without start code");
  AST_READ_OP: assert property ($rose(dev_mdio_oe) |->
    $past(mdio, 13) && !$past(mdio, 12))
    else $error("reply without read opcode");
  AST_LINE_DEV: assert property (dev_mdio_oe |-> mdio == dev_mdio_o)
    else $error("line differs from device drive");
  AST_IDLE_GAP: assert property ($fell(dev_mdio_oe) |-> !sta_mdio_oe)
    else $error("no idle bit after read");
endmodule

// ### tb/dual_port_mdio_register_access_tb.sv
// Self-checking bench joining station and device ends
`timescale 1ns/1ps
module dual_port_mdio_register_access_tb
  import dpmdio_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic link_rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] a_byp;
  logic [15:0] b_byp;
  logic [15:0] q;
  logic [31:0] r;
  int n_fail = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  dpmdio_if lnk();
  dpmdio_station u_dpmdio_station (.link(lnk), .clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  dpmdio_device u_dpmdio_device (.link(lnk), .link_rst(link_rst), .port_a_addr(5'h01),
    .port_b_addr(5'h02), .port_a_bypass(a_byp), .port_b_bypass(b_byp));
  dpmdio_sva u_dpmdio_sva (.mdc(lnk.mdc), .link_rst(link_rst), .sta_mdio_o(lnk.sta_mdio_o),
    .sta_mdio_oe(lnk.sta_mdio_oe), .dev_mdio_o(lnk.dev_mdio_o),
    .dev_mdio_oe(lnk.dev_mdio_oe), .mdio(lnk.mdio));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // Frame through the station, polled until done
  task automatic mop(input logic w, input logic [4:0] ph, input logic [4:0] rg,
                     input logic [15:0] d, output logic [15:0] rq);
    logic [31:0] s;
    int n;
    xfer(1'b1, DPMDIO_CMD_OFS, {1'b1, w, 4'h0, ph, rg, d}, s);
    n = 0;
    do begin
      xfer(1'b0, DPMDIO_STAT_OFS, 32'h0, s);
      n++;
    end while (!(n > 1 && s[17] === 1'b1 && s[16] === 1'b0) && n < 2000);
    if (n >= 2000) begin
      n_fail++;
      close_out();
    end
    rq = s[15:0];
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] ph, input logic [4:0] rg,
                        input logic [15:0] exp);
    logic [15:0] v;
    mop(1'b0, ph, rg, 16'h0000, v);
    chk(nm, {16'h0000, v}, {16'h0000, exp});
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    mop(1'b0, 5'h01, DPMDIO_REG_STATUS, 16'h0000, q);
    link_rst <= 1'b0;
    @(posedge clk);
    mop(1'b0, 5'h01, DPMDIO_REG_STATUS, 16'h0000, q);
    chk("suppr bit", {31'h0, q[DPMDIO_STATUS_SUPPR_BIT]}, 32'h1);
    mop(1'b1, 5'h01, DPMDIO_REG_STATUS, 16'hffbf, q);
    mop(1'b0, 5'h01, DPMDIO_REG_STATUS, 16'h0000, q);
    chk("suppr ro", {31'h0, q[DPMDIO_STATUS_SUPPR_BIT]}, 32'h1);
    rd_chk("status ro", 5'h01, DPMDIO_REG_STATUS, DPMDIO_STATUS_RESET);
    $display("test sync done");
    mop(1'b1, 5'h01, 5'h10, 16'ha5c3, q);
    rd_chk("a reg10", 5'h01, 5'h10, 16'ha5c3);
    rd_chk("b reg10", 5'h02, 5'h10, 16'h0000);
    mop(1'b1, 5'h02, 5'h1f, 16'h8001, q);
    rd_chk("b reg1f", 5'h02, 5'h1f, 16'h8001);
    $display("test access done");
    mop(1'b1, 5'h01, DPMDIO_REG_BYPASS, 16'h8000, q);
    chk("a bypass", {16'h0, a_byp}, 32'h8000);
    chk("b bypass", {16'h0, b_byp}, 32'h0000);
    xfer(1'b1, DPMDIO_CFG_OFS, 32'h1, r);
    mop(1'b1, 5'h01, 5'h11, 16'h1234, q);
    rd_chk("b mirror", 5'h02, 5'h11, 16'h1234);
    rd_chk("a mirror", 5'h01, 5'h11, 16'h1234);
    mop(1'b1, 5'h02, 5'h11, 16'h5555, q);
    rd_chk("a unchanged", 5'h01, 5'h11, 16'h1234);
    rd_chk("b own", 5'h02, 5'h11, 16'h5555);
    $display("test simwrite done");
    rd_chk("absent phy", 5'h1f, 5'h10, 16'hffff);
    xfer(1'b0, 8'h04, 32'h0, r);
    chk("unused 04", r, 32'h0);
    xfer(1'b0, 8'h10, 32'h0, r);
    chk("unmapped 10", r, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("test bus done");
    link_rst <= 1'b1;
    repeat (12) @(posedge clk);
    link_rst <= 1'b0;
    rd_chk("no preamble", 5'h01, DPMDIO_REG_STATUS, 16'hffff);
    xfer(1'b1, DPMDIO_CFG_OFS, 32'h0, r);
    rd_chk("resync", 5'h01, DPMDIO_REG_STATUS, DPMDIO_STATUS_RESET);
    rd_chk("a reg10 reset", 5'h01, 5'h10, DPMDIO_REG_RESET);
    chk("a bypass reset", {16'h0, a_byp}, {16'h0, DPMDIO_REG_RESET});
    $display("test reset done");
    close_out();
  end
endmodule
